/* rtl/sbtc_map.svh */
// Register addresses, field positions, reset values and timing counts of the timer/counter.
`ifndef SBTC_MAP_SVH
`define SBTC_MAP_SVH
`define SBTC_IDX_FLAG      8'h0C
`define SBTC_IDX_LOW       8'h0E
`define SBTC_IDX_HIGH      8'h0F
`define SBTC_IDX_CTRL      8'h10
`define SBTC_IDX_MASK      8'h8C
`define SBTC_ADDR_FLAG     10'h030
`define SBTC_ADDR_LOW      10'h038
`define SBTC_ADDR_HIGH     10'h03C
`define SBTC_ADDR_CTRL     10'h040
`define SBTC_ADDR_MASK     10'h230
`define SBTC_BIT_ON        0
`define SBTC_BIT_CS        1
`define SBTC_BIT_NOSYNC    2
`define SBTC_BIT_OSCEN     3
`define SBTC_PS_LSB        4
`define SBTC_PS_MSB        5
`define SBTC_BIT_OVF       0
`define SBTC_CTRL_RESET    6'h00
`define SBTC_COUNT_RESET   16'h0000
`define SBTC_COUNT_MAX     16'hFFFF
`define SBTC_CLK_PERIOD_NS 8
`define SBTC_INST_CYCLES   4
`define SBTC_INST_LAST     2'(`SBTC_INST_CYCLES - 1)
`endif

/* rtl/sbtc_pkg.sv */
// Types shared by the timer/counter design.
package sbtc_pkg;
  typedef struct packed {
    logic [15:0] count;
    logic [5:0]  ctrl;
    logic        ovfFlag;
    logic        ovfMask;
    logic [2:0]  presc;
    logic [1:0]  instPhase;
    logic        extMeta;
    logic        extSync;
    logic        extSyncPrev;
    logic        extRaw;
    logic        extRawPrev;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq;
    logic [1:0]  pinOe;
    logic        oscRun;
  } sbtc_state_type;
endpackage

/* rtl/sbtc_timer.sv */
// Sixteen-bit timer/counter with prescaler, crystal oscillator control and APB registers.
//
// Functional notes
// - Count is sixteen bits in high and low byte registers, both read/write.
// - Wrap from FFFFh to 0000h raises an overflow event.
// - Counting only while the timer-on bit 0 is set.
// - Bit 1 selects external pin rising edges or the instruction clock.
// - Internal source advances the prescaler once per instruction cycle.
// - External source advances on rising pin edges only.
// - Bit 2 zero synchronises the external input; one counts it unsynchronised.
// - With internal source the synchronisation bit is ignored.
// - Bits 5-4 select prescale 1:1, 1:2, 1:4 or 1:8.
// - Bit 3 turns the low-power crystal oscillator on or off.
// - Enabled oscillator forces both oscillator pins to inputs.
// - Oscillator keeps running while the processor sleeps.
// - Compare-unit trigger clears the count.
// - Control bits 7-6 always read as zero.
// - Overflow latches the flag unless a count write coincides; interrupt requested only when its enable is set.
// - Count write beats a coincident trigger; trigger reset never sets the flag.
`timescale 1ns/1ps
`include "sbtc_map.svh"

module sbtc_timer
  import sbtc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        externalCountPin,
  input  wire logic        compareTrigger,
  input  wire logic        sleepMode,
  input  wire logic [1:0]  portCDirection,
  output logic      [1:0]  crystalPinOe,
  output logic             crystalOscRun,
  output logic             irq
);

  sbtc_state_type q;
  sbtc_state_type d;

  logic        apbDone;
  logic        wrEn;
  logic        rdEn;
  logic        wrLow;
  logic        wrHigh;
  logic        wrCount;
  logic        timerOn;
  logic        instPulse;
  logic        extEdge;
  logic        srcPulse;
  logic [2:0]  prescLast;
  logic        incr;
  logic        overflow;
  logic        mapped;
  logic [31:0] rdData;

  assign apbDone = psel && penable && q.pready;
  assign wrEn    = apbDone && pwrite && pstrb[0];
  assign rdEn    = apbDone && !pwrite;
  assign wrLow   = wrEn && (paddr == `SBTC_ADDR_LOW);
  assign wrHigh  = wrEn && (paddr == `SBTC_ADDR_HIGH);
  assign wrCount = wrLow || wrHigh;
  assign timerOn = q.ctrl[`SBTC_BIT_ON];

  always_comb
  begin
    d         = q;
    rdData    = 32'h0000_0000;
    mapped    = 1'b1;
    prescLast = 3'h0;

    // Instruction clock runs at a quarter of the device clock.
    instPulse   = (q.instPhase == `SBTC_INST_LAST);
    d.instPhase = q.instPhase + 2'h1;

    // Synchronised and raw paths of the external input.
    d.extMeta     = externalCountPin;
    d.extSync     = q.extMeta;
    d.extSyncPrev = q.extSync;
    d.extRaw      = externalCountPin;
    d.extRawPrev  = q.extRaw;
    extEdge = q.ctrl[`SBTC_BIT_NOSYNC] ? (q.extRaw && !q.extRawPrev)
                                       : (q.extSync && !q.extSyncPrev);
    srcPulse = q.ctrl[`SBTC_BIT_CS] ? extEdge : instPulse;

    unique case (q.ctrl[`SBTC_PS_MSB:`SBTC_PS_LSB])
      2'b00: prescLast = 3'h0;
      2'b01: prescLast = 3'h1;
      2'b10: prescLast = 3'h3;
      2'b11: prescLast = 3'h7;
    endcase

    incr = timerOn && srcPulse && (q.presc >= prescLast);
    if (timerOn && srcPulse)
    begin
      d.presc = incr ? 3'h0 : q.presc + 3'h1;
    end

    overflow = incr && (q.count == `SBTC_COUNT_MAX);
    if (incr)
    begin
      d.count = q.count + 16'h0001;
    end

    if (compareTrigger)
    begin
      d.count = `SBTC_COUNT_RESET;
      d.presc = 3'h0;
    end

    if (wrLow)
    begin
      d.count[7:0] = pwdata[7:0];
      d.presc      = 3'h0;
    end
    if (wrHigh)
    begin
      d.count[15:8] = pwdata[7:0];
      d.presc       = 3'h0;
    end
    if (wrEn && (paddr == `SBTC_ADDR_CTRL))
    begin
      d.ctrl = pwdata[5:0];
    end
    if (wrEn && (paddr == `SBTC_ADDR_MASK))
    begin
      d.ovfMask = pwdata[`SBTC_BIT_OVF];
    end

    if (rdEn && (paddr == `SBTC_ADDR_FLAG))
    begin
      d.ovfFlag = 1'b0;
    end
    if (overflow && !wrCount)
    begin
      d.ovfFlag = 1'b1;
    end

    d.irq = q.ovfFlag && q.ovfMask;

    d.oscRun = q.ctrl[`SBTC_BIT_OSCEN] || (sleepMode && q.ctrl[`SBTC_BIT_OSCEN]);
    d.pinOe = q.ctrl[`SBTC_BIT_OSCEN] ? 2'b00 : ~portCDirection;

    // Register read multiplexer.
    unique case (paddr)
      `SBTC_ADDR_FLAG: rdData = {31'h0000_0000, q.ovfFlag};
      `SBTC_ADDR_MASK: rdData = {31'h0000_0000, q.ovfMask};
      `SBTC_ADDR_LOW:  rdData = {24'h00_0000, q.count[7:0]};
      `SBTC_ADDR_HIGH: rdData = {24'h00_0000, q.count[15:8]};
      `SBTC_ADDR_CTRL: rdData = {26'h000_0000, q.ctrl};
      default:         mapped = 1'b0;
    endcase

    // One wait state: data and ready are registered in the first access cycle.
    d.pready  = psel && penable && !q.pready;
    d.pslverr = psel && penable && !q.pready && !mapped;
    if (psel && penable && !q.pready)
    begin
      d.prdata = pwrite ? 32'h0000_0000 : rdData;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '{count: `SBTC_COUNT_RESET, ctrl: `SBTC_CTRL_RESET, prdata: 32'h0000_0000,
             presc: 3'h0, instPhase: 2'h0, pinOe: 2'b00, default: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata       = q.prdata;
  assign pready       = q.pready;
  assign pslverr      = q.pslverr;
  assign crystalPinOe = q.pinOe;
  assign crystalOscRun = q.oscRun;
  assign irq          = q.irq;

  sequence sWrapStep;
    incr && (q.count == `SBTC_COUNT_MAX) && !wrCount && !compareTrigger;
  endsequence

  sequence sCleared;
    (q.count == 16'h0000) && q.ovfFlag;
  endsequence

  AST_OVF_WRAP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sWrapStep |=> sCleared)
    else $error("Wrap did not clear count and set flag.");

  AST_STOP_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !timerOn && !wrCount && !compareTrigger |=> $stable(q.count))
    else $error("Stopped counter changed.");

  AST_INT_STEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    timerOn && !q.ctrl[`SBTC_BIT_CS] && (prescLast == 3'h0) && instPulse && !wrCount && !compareTrigger
    |=> q.count == $past(q.count) + 16'h0001)
    else $error("Internal source did not advance the count.");

  AST_INT_PERIOD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    incr && !q.ctrl[`SBTC_BIT_CS] |=> !incr [*3])
    else $error("Internal source counted faster than one per instruction.");

  AST_EXT_EDGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q.ctrl[`SBTC_BIT_CS] && incr |-> extEdge)
    else $error("External count without a rising edge.");

  AST_PRESC: assert property (@(posedge ref_clk) disable iff (!rst_n)
    incr |-> (q.presc >= prescLast) && srcPulse)
    else $error("Prescaler released a count early.");

  AST_TRIG_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    compareTrigger && !wrCount |=> q.count == 16'h0000)
    else $error("Trigger did not clear the count.");

  AST_WRITE_WINS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    compareTrigger && wrLow |=> q.count[7:0] == $past(pwdata[7:0]))
    else $error("Trigger overrode a count write.");

  AST_TRIG_NOFLAG: assert property (@(posedge ref_clk) disable iff (!rst_n)
    compareTrigger && !q.ovfFlag && !incr |=> !q.ovfFlag)
    else $error("Trigger reset set the overflow flag.");

  AST_PIN_INPUT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q.ctrl[`SBTC_BIT_OSCEN] |=> crystalPinOe == 2'b00)
    else $error("Oscillator pins driven while oscillator enabled.");

  AST_OSC_SLEEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q.ctrl[`SBTC_BIT_OSCEN] && sleepMode |=> crystalOscRun)
    else $error("Oscillator stopped in sleep.");

  AST_IRQ_MASK: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irq |-> $past(q.ovfFlag) && $past(q.ovfMask))
    else $error("Interrupt without enabled flag.");

  AST_CTRL_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
    psel && penable && !q.pready && !pwrite && (paddr == `SBTC_ADDR_CTRL) |=> prdata[7:6] == 2'b00)
    else $error("Unimplemented control bits read non-zero.");

  AST_RUN_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    incr |-> timerOn)
    else $error("Counted while timer off.");

  sequence sFlagReadNoWrap;
    rdEn && (paddr == `SBTC_ADDR_FLAG) && !overflow;
  endsequence

  AST_FLAG_STICKY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q.ovfFlag && !(rdEn && (paddr == `SBTC_ADDR_FLAG)) |=> q.ovfFlag)
    else $error("Overflow flag dropped without a read.");

  AST_FLAG_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sFlagReadNoWrap |=> !q.ovfFlag)
    else $error("Flag read did not clear the flag.");

  AST_IRQ_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q.ovfFlag && q.ovfMask |=> irq)
    else $error("Unmasked flag raised no interrupt.");

  AST_IRQ_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !q.ovfMask |=> !irq)
    else $error("Interrupt raised while masked.");

  AST_WR_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrLow |=> q.count[7:0] == $past(pwdata[7:0]))
    else $error("Low byte write did not land.");

  AST_WR_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrHigh |=> q.count[15:8] == $past(pwdata[7:0]))
    else $error("High byte write did not land.");

  AST_RD_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
    psel && penable && !q.pready && !pwrite && (paddr == `SBTC_ADDR_LOW)
    |=> prdata == {24'h00_0000, $past(q.count[7:0])})
    else $error("Low byte read returned a wrong value.");

  AST_CTRL_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrEn && (paddr == `SBTC_ADDR_CTRL) |=> q.ctrl == $past(pwdata[5:0]))
    else $error("Control write did not land.");

  AST_OSC_ON: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q.ctrl[`SBTC_BIT_OSCEN] |=> crystalOscRun)
    else $error("Oscillator not running while enabled.");

  AST_OSC_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !q.ctrl[`SBTC_BIT_OSCEN] |=> !crystalOscRun)
    else $error("Oscillator running while disabled.");

  AST_PIN_DIR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !q.ctrl[`SBTC_BIT_OSCEN] |=> crystalPinOe == ~$past(portCDirection))
    else $error("Pin enables ignore the direction bits.");

  AST_SYNC_EDGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !q.ctrl[`SBTC_BIT_NOSYNC] |-> extEdge == ($past(externalCountPin, 2) && !$past(externalCountPin, 3)))
    else $error("Synchronised edge does not follow the pin.");

  AST_RAW_EDGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q.ctrl[`SBTC_BIT_NOSYNC] |-> extEdge == ($past(externalCountPin, 1) && !$past(externalCountPin, 2)))
    else $error("Unsynchronised edge does not follow the pin.");

  AST_EXT_ONLY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q.ctrl[`SBTC_BIT_CS] && !extEdge |-> !incr)
    else $error("Pin source counted without a pin edge.");

  AST_INT_ONLY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !q.ctrl[`SBTC_BIT_CS] && !instPulse |-> !incr)
    else $error("Internal source counted off the instruction clock.");

  AST_TRIG_PRESC: assert property (@(posedge ref_clk) disable iff (!rst_n)
    compareTrigger |=> q.presc == 3'h0)
    else $error("Trigger left the prescaler running.");

  AST_PRESC_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !timerOn && !wrCount && !compareTrigger |=> $stable(q.presc))
    else $error("Stopped prescaler changed.");

endmodule

/* tb/sbtc_ext_src.sv */
// Model of the external clock source that drives the count pin in bursts.
`timescale 1ns/1ps
module sbtc_ext_src
(
  input  wire logic ref_clk,
  output logic      pin
);
  initial pin = 1'b0;

  // The pin rests low between bursts, so each pulse gives exactly one rising edge.
  task automatic burst(input int n, input int half);
    for (int i = 0; i < n; i++)
    begin
      @(posedge ref_clk);
      pin <= 1'b1;
      repeat (half) @(posedge ref_clk);
      pin <= 1'b0;
      repeat (half - 1) @(posedge ref_clk);
    end
  endtask
endmodule

/* tb/test_sixteen_bit_timer_counter.sv */
// Self-checking bench of the timer/counter over its register bus and pins.
`timescale 1ns/1ps
`include "sbtc_map.svh"
module test_sixteen_bit_timer_counter;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [9:0]  paddr = 10'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, cnt, rnd;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, extPin, crystalOscRun, irq, lastErr;
  logic        compareTrigger = 1'b0, sleepMode = 1'b0;
  logic [1:0]  portCDirection = 2'b00, crystalPinOe;
  int          errorCnt = 0, nChecks = 0, cycles = 0, n;

  always #4 ref_clk = ~ref_clk;

  sbtc_timer i_sbtc_timer (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .externalCountPin(extPin), .compareTrigger(compareTrigger), .sleepMode(sleepMode),
    .portCDirection(portCDirection), .crystalPinOe(crystalPinOe), .crystalOscRun(crystalOscRun), .irq(irq));
  sbtc_ext_src i_sbtc_ext_src (.ref_clk(ref_clk), .pin(extPin));

  task automatic closeOut;
    $display("checks %0d errors %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input string what, input logic [9:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(what, rd, e);
  endtask

  task automatic rdcnt;
    apb(1'b0, `SBTC_ADDR_LOW, 32'h0);
    cnt = {24'h0, rd[7:0]};
    apb(1'b0, `SBTC_ADDR_HIGH, 32'h0);
    cnt = cnt | {16'h0, rd[7:0], 8'h0};
  endtask

  function automatic int expInt(input int w, input int ps);
    return (w + 3) / (4 << ps);
  endfunction

  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      errorCnt++;
      closeOut();
    end
  end

  initial
  begin
    void'($urandom(38904));
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdchk("control reset", `SBTC_ADDR_CTRL, 32'h0);
    rdchk("low reset", `SBTC_ADDR_LOW, 32'h0);
    rdchk("high reset", `SBTC_ADDR_HIGH, 32'h0);
    rdchk("flag reset", `SBTC_ADDR_FLAG, 32'h0);
    rdchk("mask reset", `SBTC_ADDR_MASK, 32'h0);
    apb(1'b0, 10'h004, 32'h0);
    check("unmapped error", {31'h0, lastErr}, 32'h1);
    rnd = $urandom;
    wr(`SBTC_ADDR_LOW, {24'h0, rnd[7:0]});
    wr(`SBTC_ADDR_HIGH, {24'h0, rnd[15:8]});
    repeat (20) @(posedge ref_clk);
    rdcnt;
    check("count held", cnt, {16'h0, rnd[15:0]});
    pstrb <= 4'hE;
    wr(`SBTC_ADDR_LOW, {24'h0, ~rnd[7:0]});
    pstrb <= 4'hF;
    rdchk("strobe-less write", `SBTC_ADDR_LOW, {24'h0, rnd[7:0]});
    for (int i = 0; i < 4; i++)
    begin
      wr(`SBTC_ADDR_LOW, 32'h0);
      wr(`SBTC_ADDR_HIGH, 32'h0);
      wr(`SBTC_ADDR_CTRL, 32'(i << 4) | 32'h1 | (32'($urandom) & 32'h4));
      repeat (640) @(posedge ref_clk);
      wr(`SBTC_ADDR_CTRL, 32'h0);
      rdcnt;
      n = int'(cnt) - expInt(640, i);
      check("internal count", {31'h0, (n >= -1 && n <= 1)}, 32'h1);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(`SBTC_ADDR_LOW, 32'h0);
      wr(`SBTC_ADDR_HIGH, 32'h0);
      wr(`SBTC_ADDR_CTRL, 32'(i << 4) | 32'h3 | 32'((i % 2) << 2));
      rnd = $urandom_range(24, 8);
      i_sbtc_ext_src.burst(int'(rnd), 5);
      repeat (8) @(posedge ref_clk);
      wr(`SBTC_ADDR_CTRL, 32'h0);
      rdcnt;
      check("external count", cnt, rnd >> i);
    end
    wr(`SBTC_ADDR_LOW, 32'hFA);
    wr(`SBTC_ADDR_HIGH, 32'hFF);
    wr(`SBTC_ADDR_CTRL, 32'h1);
    repeat (40) @(posedge ref_clk);
    wr(`SBTC_ADDR_CTRL, 32'h0);
    rdchk("high after wrap", `SBTC_ADDR_HIGH, 32'h0);
    check("irq while masked", {31'h0, irq}, 32'h0);
    wr(`SBTC_ADDR_MASK, 32'h1);
    repeat (2) @(posedge ref_clk);
    check("irq unmasked", {31'h0, irq}, 32'h1);
    rdchk("flag set", `SBTC_ADDR_FLAG, 32'h1);
    rdchk("flag cleared", `SBTC_ADDR_FLAG, 32'h0);
    repeat (2) @(posedge ref_clk);
    check("irq after clear", {31'h0, irq}, 32'h0);
    wr(`SBTC_ADDR_LOW, 32'h55);
    @(posedge ref_clk);
    compareTrigger <= 1'b1;
    @(posedge ref_clk);
    compareTrigger <= 1'b0;
    rdcnt;
    check("count after trigger", cnt, 32'h0);
    rdchk("flag after trigger", `SBTC_ADDR_FLAG, 32'h0);
    wr(`SBTC_ADDR_HIGH, 32'h12);
    fork
      wr(`SBTC_ADDR_LOW, 32'h66);
      begin
        repeat (3) @(posedge ref_clk);
        compareTrigger <= 1'b1;
        @(posedge ref_clk);
        compareTrigger <= 1'b0;
      end
    join
    rdchk("low write beats trigger", `SBTC_ADDR_LOW, 32'h66);
    wr(`SBTC_ADDR_CTRL, 32'h1);
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdchk("control after reset", `SBTC_ADDR_CTRL, 32'h0);
    rdcnt;
    check("count after reset", cnt, 32'h0);
    portCDirection <= 2'($urandom);
    sleepMode <= 1'b1;
    wr(`SBTC_ADDR_CTRL, 32'hFF);
    repeat (50) @(posedge ref_clk);
    rdchk("control upper bits", `SBTC_ADDR_CTRL, 32'h3F);
    check("oscillator running", {31'h0, crystalOscRun}, 32'h1);
    check("pins forced input", {30'h0, crystalPinOe}, 32'h0);
    wr(`SBTC_ADDR_CTRL, 32'h0);
    repeat (2) @(posedge ref_clk);
    check("oscillator off", {31'h0, crystalOscRun}, 32'h0);
    check("pin direction", {30'h0, crystalPinOe}, {30'h0, ~portCDirection});
    closeOut();
  end
endmodule
